// file: deque_state_vector_cfg.svh
// Constants for the double-ended state vector: capacity, element precision
// and input precision defaults.
// Assumes it is included by its bare name wherever the values are needed.
`ifndef DEQUE_STATE_VECTOR_CFG_SVH
`define DEQUE_STATE_VECTOR_CFG_SVH

// Capacity limit of the vector in elements.
`define DQ_MAX_LEN      8
// Stored element width and fractional bits.
`define DQ_ELEM_WIDTH   16
`define DQ_ELEM_FRAC    8
// Width and fractional bits of the incoming operand.
`define DQ_IN_WIDTH     20
`define DQ_IN_FRAC      12
// Number of elements held after reset (any count from empty to full).
`define DQ_INIT_LEN     8
// Constant initial element value.
`define DQ_INIT_VALUE   16'h0000

`endif

// file: deque_state_vector_pkg.sv
// Types shared by the double-ended state vector, its partner model and its bench.
// Assumes nothing of its surroundings.
`default_nettype none

package deque_state_vector_pkg;

    // Update operation requested in one cycle; queries are separate ports.
    typedef enum logic [2:0] {
        OP_NONE,
        OP_WRITE,
        OP_PUSH_FRONT,
        OP_POP_FRONT,
        OP_PUSH_BACK,
        OP_POP_BACK,
        OP_SHIFT
    } dq_op_t;

endpackage

`default_nettype wire

// file: dq_qnt_if.sv
// Carrier between the vector and its quantiser: raw operand, mode bits and
// the value at element precision.
// Assumes both ends are in the same clock domain (it is purely combinational).
`timescale 1ns/1ns
`default_nettype none

interface dq_qnt_if #(
    parameter int IN_W = 20,
    parameter int W    = 16
);
    logic [IN_W-1:0] raw;       // Operand at input precision.
    logic            round_en;  // Round to nearest instead of truncate.
    logic            sat_en;    // Saturate instead of wrap on overflow.
    logic [W-1:0]    q;         // Operand at element precision.

    modport user (output raw, output round_en, output sat_en, input q);
    modport unit (input raw, input round_en, input sat_en, output q);
endinterface

`default_nettype wire

// file: dq_quantize.sv
// Fixed-point conversion of a signed operand to the element precision,
// with optional rounding and saturation.
// Assumes the input has at least as many fractional bits as the element.
`timescale 1ns/1ns
`default_nettype none

module dq_quantize #(
    parameter int IN_W    = 20,
    parameter int IN_FRAC = 12,
    parameter int W       = 16,
    parameter int FRAC    = 8
) (
    // Operand in, quantised value out.
    dq_qnt_if.unit qi
);
    localparam int SHIFT = IN_FRAC - FRAC;
    localparam int EW    = IN_W + 1;
    localparam int HPOS  = (SHIFT > 0) ? SHIFT - 1 : 0;
    // Half of one output step, added when rounding.
    localparam logic [EW-1:0] HALF = (SHIFT > 0) ? (EW'(1) << HPOS) : '0;
    // Largest and smallest values the element can hold.
    localparam logic [EW-1:0] MAXV = {{(EW-W+1){1'b0}}, {(W-1){1'b1}}};
    localparam logic [EW-1:0] MINV = {{(EW-W+1){1'b1}}, {(W-1){1'b0}}};

    // Refuse precisions the shifter cannot serve, while elaborating.
    if (SHIFT < 0 || IN_W < W || W < 2) begin : gen_bad_precision
        $error("dq_quantize: unsupported precision");
    end

    logic signed [EW-1:0] ext;  // Sign-extended operand.
    logic signed [EW-1:0] sum;  // Operand after the rounding offset.
    logic signed [EW-1:0] shr;  // Operand aligned to the element point.

    // Round, align and then clip or wrap into the element width.
    always_comb begin
        ext = {qi.raw[IN_W-1], qi.raw};
        sum = ext + (qi.round_en ? $signed(HALF) : $signed(EW'(0)));
        shr = sum >>> SHIFT;
        if (qi.sat_en && shr > $signed(MAXV)) begin
            qi.q = MAXV[W-1:0];
        end else if (qi.sat_en && shr < $signed(MINV)) begin
            qi.q = MINV[W-1:0];
        end else begin
            qi.q = shr[W-1:0];
        end
    end
endmodule // dq_quantize

`default_nettype wire

// file: deque_state_vector.sv
// Bounded double-ended queue of fixed-point elements held as a state vector.
// Assumes the driving logic shares clk_i and presents one update per cycle.
`timescale 1ns/1ns
`default_nettype none

`include "deque_state_vector_cfg.svh"

module deque_state_vector
    import deque_state_vector_pkg::*;
#(
    parameter int MAX_LEN  = `DQ_MAX_LEN,
    parameter int W        = `DQ_ELEM_WIDTH,
    parameter int FRAC     = `DQ_ELEM_FRAC,
    parameter int IN_W     = `DQ_IN_WIDTH,
    parameter int IN_FRAC  = `DQ_IN_FRAC,
    parameter int INIT_LEN = `DQ_INIT_LEN,
    parameter logic [W-1:0] INIT_VALUE = `DQ_INIT_VALUE,
    localparam int AW = $clog2(MAX_LEN),
    localparam int LW = $clog2(MAX_LEN + 1)
) (
    // Clock, reset and clock enable.
    input  wire logic            clk_i,
    input  wire logic            reset_i,
    input  wire logic            ce_i,
    // Update request.
    input  wire dq_op_t          op_i,
    input  wire logic [AW-1:0]   wr_addr_i,
    input  wire logic [IN_W-1:0] din_i,
    input  wire logic            round_en_i,
    input  wire logic            sat_en_i,
    // Query requests.
    input  wire logic [AW-1:0]   rd_addr_i,
    input  wire logic            head_rd_i,
    input  wire logic            tail_rd_i,
    // Query answers.
    output logic [W-1:0]         rd_data_o,
    output logic [W-1:0]         head_o,
    output logic [W-1:0]         tail_o,
    // Status.
    output logic                 err_o,
    output logic                 full_o,
    output logic                 empty_o,
    output logic [LW-1:0]        length_o,
    output logic [LW-1:0]        max_len_o
);

    // Refuse shapes the storage cannot serve, while elaborating.
    if (MAX_LEN < 2 || INIT_LEN < 0
        || INIT_LEN > MAX_LEN) begin : gen_bad_shape
        $error("deque_state_vector: unsupported capacity or length");
    end

    localparam logic [LW-1:0] CAP   = LW'(MAX_LEN);   // Capacity as count.
    localparam logic [LW-1:0] ILEN  = LW'(INIT_LEN);  // Length after reset.
    localparam logic [LW-1:0] ONE_L = LW'(1);         // Length step.

    logic [W-1:0]  mem_r [MAX_LEN];  // Element storage, head at index 0.
    logic [LW-1:0] len_r;            // Current number of elements.
    logic [W-1:0]  rd_data_r;        // Registered indexed read.
    logic [W-1:0]  head_r;           // Registered head value.
    logic [W-1:0]  tail_r;           // Registered tail value.
    logic          err_r;            // Registered misuse indication.
    logic [W-1:0]  qval;             // Operand at element precision.
    logic          is_full;          // Length at capacity.
    logic          is_empty;         // No elements held.
    logic [AW-1:0] tail_idx;         // Address of the tail element.
    logic          op_err;           // Update refused this cycle.
    logic          qry_err;          // Head or tail query made on an empty vector.
    logic          do_op;            // Update accepted this cycle.

    // Operand conversion to the element precision.
    dq_qnt_if #(.IN_W(IN_W), .W(W)) qnt ();

    assign qnt.raw      = din_i;
    assign qnt.round_en = round_en_i;
    assign qnt.sat_en   = sat_en_i;
    assign qval         = qnt.q;

    dq_quantize #(
        .IN_W    (IN_W),
        .IN_FRAC (IN_FRAC),
        .W       (W),
        .FRAC    (FRAC)
    ) u_quantize (
        .qi (qnt.unit)
    );

    // Status derived from the stored length only, so queries never disturb
    // the state.
    assign is_full  = (len_r == CAP);
    assign is_empty = (len_r == '0);
    assign tail_idx = is_empty ? '0 : AW'(len_r - ONE_L);

    // Misuse detection for each update and for head and tail queries.
    always_comb begin
        case (op_i)
            OP_PUSH_FRONT: op_err = is_full;
            OP_PUSH_BACK:  op_err = is_full;
            OP_POP_FRONT:  op_err = is_empty;
            OP_POP_BACK:   op_err = is_empty;
            OP_SHIFT:      op_err = is_empty;
            OP_WRITE:      op_err = (32'(wr_addr_i) >= MAX_LEN);
            default:       op_err = 1'b0;
        endcase
        qry_err = is_empty && (head_rd_i || tail_rd_i);
    end

    assign do_op = ce_i && (op_i != OP_NONE) && !op_err;

    // Element storage. Reads below sample the array at the same edge that
    // applies the update, so every query sees the previous cycle's state.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < MAX_LEN; i++) begin
                mem_r[i] <= INIT_VALUE;
            end
        end else if (do_op) begin
            case (op_i)
                OP_WRITE: begin
                    mem_r[wr_addr_i] <= qval;
                end
                OP_PUSH_FRONT, OP_SHIFT: begin
                    for (int i = MAX_LEN - 1; i > 0; i--) begin
                        mem_r[i] <= mem_r[i-1];
                    end
                    mem_r[0] <= qval;
                end
                OP_POP_FRONT: begin
                    for (int i = 0; i < MAX_LEN - 1; i++) begin
                        mem_r[i] <= mem_r[i+1];
                    end
                end
                OP_PUSH_BACK: begin
                    mem_r[AW'(len_r)] <= qval;
                end
                default: begin
                    // Removal at the tail only shortens the length.
                end
            endcase
        end
    end

    // Current length; starts at INIT_LEN, anywhere from empty to full.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            len_r <= ILEN;
        end else if (do_op) begin
            case (op_i)
                OP_PUSH_FRONT, OP_PUSH_BACK: len_r <= len_r + ONE_L;
                OP_POP_FRONT, OP_POP_BACK:   len_r <= len_r - ONE_L;
                default:                     len_r <= len_r;
            endcase
        end
    end

    // Query answers taken from the state before this cycle's update.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_data_r <= '0;
            head_r    <= '0;
            tail_r    <= '0;
        end else if (ce_i) begin
            if (32'(rd_addr_i) < MAX_LEN) begin
                rd_data_r <= mem_r[rd_addr_i];
            end else begin
                rd_data_r <= '0;
            end
            head_r <= mem_r[0];
            tail_r <= mem_r[tail_idx];
        end
    end

    // One-cycle misuse pulse for the request taken at the previous edge.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            err_r <= 1'b0;
        end else if (ce_i) begin
            err_r <= qry_err || ((op_i != OP_NONE) && op_err);
        end
    end

    assign rd_data_o = rd_data_r;
    assign head_o    = head_r;
    assign tail_o    = tail_r;
    assign err_o     = err_r;
    assign full_o    = is_full;
    assign empty_o   = is_empty;
    assign length_o  = len_r;
    assign max_len_o = CAP;

    // A push accepted on a non-full vector.
    sequence push_ok_s;
        ce_i && !is_full && (op_i == OP_PUSH_FRONT || op_i == OP_PUSH_BACK);
    endsequence

    // A pop accepted on a non-empty vector.
    sequence pop_ok_s;
        ce_i && !is_empty && (op_i == OP_POP_FRONT || op_i == OP_POP_BACK);
    endsequence

    length_grows_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        push_ok_s |=> len_r == $past(len_r) + ONE_L
    ) else $error("length did not grow on push");

    length_shrinks_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        pop_ok_s |=> len_r == $past(len_r) - ONE_L
    ) else $error("length did not shrink on pop");

    full_refused_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && is_full && op_i == OP_PUSH_BACK
        |=> err_o && len_r == CAP
    ) else $error("push on full vector not refused");

    empty_refused_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && is_empty && op_i == OP_POP_FRONT
        |=> err_o && len_r == '0
    ) else $error("pop on empty vector not refused");

    head_push_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !is_full && op_i == OP_PUSH_FRONT
        |=> mem_r[0] == $past(qval) && mem_r[1] == $past(mem_r[0])
    ) else $error("head insertion misplaced");

    shift_keeps_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !is_empty && op_i == OP_SHIFT
        |=> len_r == $past(len_r) && mem_r[0] == $past(qval)
    ) else $error("shift changed length or head");

    full_status_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        full_o == (length_o == max_len_o) && !(full_o && empty_o)
    ) else $error("full status wrong");

    old_read_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && op_i == OP_WRITE && wr_addr_i == rd_addr_i
        |=> rd_data_o == $past(mem_r[rd_addr_i])
            && mem_r[$past(rd_addr_i)] == $past(qval)
    ) else $error("same-address read not old contents");

    tail_read_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !is_empty |=> tail_o == $past(mem_r[tail_idx])
    ) else $error("tail read wrong");

    query_err_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && is_empty && head_rd_i |=> err_o
    ) else $error("head read on empty vector not flagged");

    freeze_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !ce_i |=> $stable(len_r) && $stable(rd_data_o) && $stable(err_o)
    ) else $error("state moved with clock enable low");

    reset_load_a: assert property (
        @(posedge clk_i)
        reset_i |=> len_r == ILEN && mem_r[0] == INIT_VALUE && !err_o
    ) else $error("reset did not load initial contents");

    // A push at the tail lands at the old length and becomes the tail.
    tail_push_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !is_full && op_i == OP_PUSH_BACK
        |=> mem_r[tail_idx] == $past(qval)
    ) else $error("tail append misplaced");

    // Removal at the head moves every element one place towards it.
    head_pop_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !is_empty && op_i == OP_POP_FRONT
        |=> mem_r[0] == $past(mem_r[1])
    ) else $error("head removal did not shift down");

    // Removal at the tail leaves the head where it was.
    tail_pop_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !is_empty && op_i == OP_POP_BACK
        |=> mem_r[0] == $past(mem_r[0]) && len_r == $past(len_r) - ONE_L
    ) else $error("tail removal disturbed the head");

    // An accepted indexed write is visible at its address next cycle.
    write_lands_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !op_err && op_i == OP_WRITE
        |=> mem_r[$past(wr_addr_i)] == $past(qval)
    ) else $error("indexed write did not land");

    // An indexed read answers with the element before this edge.
    index_read_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && 32'(rd_addr_i) < MAX_LEN
        |=> rd_data_o == $past(mem_r[rd_addr_i])
    ) else $error("indexed read wrong");

    // The head answer is always the element at address zero.
    head_read_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i |=> head_o == $past(mem_r[0])
    ) else $error("head read wrong");

    // A head insertion on a full vector is refused with an error.
    front_refused_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && is_full && op_i == OP_PUSH_FRONT
        |=> err_o && len_r == CAP
    ) else $error("head insert on full vector not refused");

    // Without misuse the error indication stays low.
    err_clear_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !op_err && !qry_err |=> !err_o
    ) else $error("error raised without misuse");

    // A low clock enable also holds the elements and their answers.
    freeze_mem_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !ce_i |=> $stable(mem_r[0]) && $stable(head_o) && $stable(tail_o)
    ) else $error("elements moved with clock enable low");

    // A shift moves the old head one place towards the tail.
    shift_drops_a: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !is_empty && op_i == OP_SHIFT
        |=> mem_r[1] == $past(mem_r[0])
    ) else $error("shift did not move the old head");

endmodule // deque_state_vector

`default_nettype wire

// file: dq_datapath_model.sv
// Partner model: the datapath logic that sends one queue request a cycle.
// Assumes calls start at a falling edge of clk_i, one request per call.
`timescale 1ns/1ns
`default_nettype none

module dq_datapath_model
    import deque_state_vector_pkg::*;
(
    // Clock shared with the vector.
    input  wire logic   clk_i,
    // Request towards the vector.
    output dq_op_t      op_o,
    output logic [2:0]  wr_addr_o,
    output logic [19:0] din_o,
    output logic        round_en_o,
    output logic        sat_en_o,
    output logic [2:0]  rd_addr_o,
    output logic        head_rd_o,
    output logic        tail_rd_o
);
    // Queries and the update go out together; the vector must answer the
    // queries from its contents before the update lands.
    // A shift on an empty vector goes out only when the caller asks for it.
    task automatic issue(input dq_op_t op, input logic [2:0] wa,
        input logic [19:0] d, input logic rn, input logic st,
        input logic [2:0] ra, input logic hr, input logic tr);
        op_o       = op;
        wr_addr_o  = wa;
        din_o      = d;
        round_en_o = rn;
        sat_en_o   = st;
        rd_addr_o  = ra;
        head_rd_o  = hr;
        tail_rd_o  = tr;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // Idle: no update, and the operand is garbage rather than old data.
    task automatic idle();
        op_o      = OP_NONE;
        din_o     = ~din_o;
        head_rd_o = 1'b0;
        tail_rd_o = 1'b0;
    endtask

    // Quiet request lines from time zero.
    initial begin
        op_o       = OP_NONE;
        wr_addr_o  = 3'h0;
        din_o      = 20'h0_0000;
        round_en_o = 1'b0;
        sat_en_o   = 1'b0;
        rd_addr_o  = 3'h0;
        head_rd_o  = 1'b0;
        tail_rd_o  = 1'b0;
    end
endmodule // dq_datapath_model

`default_nettype wire

// file: test_deque_state_vector.sv
// Self-checking bench for the double-ended state vector.
// Assumes the partner model in dq_datapath_model.sv and default parameters.
`timescale 1ns/1ns
`default_nettype none

`include "deque_state_vector_cfg.svh"

module test_deque_state_vector
    import deque_state_vector_pkg::*;
;
    // One table row: request, then answers seen after its edge.
    typedef struct {
        dq_op_t op; logic [2:0] wa; logic [19:0] d; logic rn; logic st;
        logic [2:0] ra; logic hr; logic tr;
        logic [15:0] rd; logic [15:0] hd; logic [15:0] tl;
        logic [3:0] len; logic err;
    } row_t;

    logic        clk_i = 1'b0;  // 250 MHz clock.
    logic        reset_i = 1'b1; // Synchronous reset.
    logic        ce_i = 1'b1;   // Clock enable.
    dq_op_t      op;            // Partner request lines.
    logic [2:0]  wa, ra;
    logic [19:0] din;
    logic        rn, st, hr, tr;
    logic [15:0] rd_data, head, tail; // Vector answers.
    logic        err, full, empty;
    logic [3:0]  length, max_len;
    int          n_fail = 0;          // Mismatches seen.
    int          samples_checked = 0; // Comparisons made.
    int          cycles = 0;          // Clock cycles run.
    dq_op_t      bad_ops[5];          // Misuse on an empty vector.
    row_t        rows[10];

    always #2 clk_i = ~clk_i;

    dq_datapath_model i_dq_datapath_model (.clk_i(clk_i), .op_o(op),
        .wr_addr_o(wa), .din_o(din), .round_en_o(rn), .sat_en_o(st),
        .rd_addr_o(ra), .head_rd_o(hr), .tail_rd_o(tr));

    deque_state_vector i_deque_state_vector (.clk_i(clk_i),
        .reset_i(reset_i), .ce_i(ce_i), .op_i(op), .wr_addr_i(wa),
        .din_i(din), .round_en_i(rn), .sat_en_i(st), .rd_addr_i(ra),
        .head_rd_i(hr), .tail_rd_i(tr), .rd_data_o(rd_data),
        .head_o(head), .tail_o(tail), .err_o(err), .full_o(full),
        .empty_o(empty), .length_o(length), .max_len_o(max_len));

    // Compare an element value.
    task automatic chk_w(input string nm, input logic [15:0] e, input
        logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Compare a length value.
    task automatic chk_l(input string nm, input logic [3:0] e, input
        logic [3:0] s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %0d seen %0d", nm, e, s);
        end
    endtask

    // Compare a flag.
    task automatic chk_b(input string nm, input logic e, input logic s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", nm, e, s);
        end
    endtask

    // Verdict and end of run.
    task automatic complete_run();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and ends the run.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            complete_run();
        end
    end

    // Main sequence: table rows, then the awkward cases and a second reset.
    initial begin
        rows = '{
        '{OP_PUSH_FRONT, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8, 1},
        '{OP_PUSH_BACK, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 8, 1},
        '{OP_WRITE, 2, 20'h0_023F, 0, 0, 2, 0, 0, 0, 0, 0, 8, 0},
        '{OP_POP_BACK, 0, 0, 0, 0, 2, 0, 0, 16'h0023, 0, 0, 7, 0},
        '{OP_POP_FRONT, 0, 0, 0, 0, 2, 0, 0, 16'h0023, 0, 0, 6, 0},
        '{OP_PUSH_FRONT, 0, 20'hF_FFF1, 0, 0, 1, 1, 0, 16'h0023, 0, 0, 7, 0},
        '{OP_PUSH_BACK, 0, 20'h0_0058, 1, 0, 2, 0, 1, 16'h0023, 16'hFFFF,
          0, 8, 0},
        '{OP_SHIFT, 0, 20'h7_FFF8, 1, 1, 7, 0, 0, 16'h0006, 16'hFFFF,
          16'h0006, 8, 0},
        '{OP_SHIFT, 0, 20'h7_FFF8, 1, 0, 0, 0, 0, 16'h7FFF, 16'h7FFF,
          0, 8, 0},
        '{OP_NONE, 0, 0, 0, 0, 4, 1, 1, 16'h0023, 16'h8000, 0, 8, 0}};
        bad_ops = '{OP_NONE, OP_NONE, OP_POP_FRONT, OP_POP_BACK, OP_SHIFT};
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        chk_l("length", 4'h8, length);
        chk_l("max_len", `DQ_MAX_LEN, max_len);
        chk_b("full", 1'b1, full);
        chk_w("head", 16'h0000, head);
        foreach (rows[i]) begin
            i_dq_datapath_model.issue(rows[i].op, rows[i].wa,
                rows[i].d, rows[i].rn, rows[i].st, rows[i].ra,
                rows[i].hr, rows[i].tr);
            chk_w("rd_data", rows[i].rd, rd_data);
            chk_w("head", rows[i].hd, head);
            chk_w("tail", rows[i].tl, tail);
            chk_l("length", rows[i].len, length);
            chk_b("err", rows[i].err, err);
            chk_b("full", rows[i].len == 8, full);
        end
        // A frozen clock enable keeps the previous state.
        ce_i = 1'b0;
        i_dq_datapath_model.issue(OP_POP_FRONT, 0, 0, 0, 0, 0, 0, 0);
        chk_l("length", 4'h8, length);
        ce_i = 1'b1;
        // Drain to empty back to back.
        for (int i = 0; i < 8; i++) begin
            i_dq_datapath_model.issue(OP_POP_FRONT, 0, 0, 0,
                0, 0, 0, 0);
            chk_l("length", 4'(7 - i), length);
        end
        chk_b("empty", 1'b1, empty);
        chk_b("full", 1'b0, full);
        // Every misuse of an empty vector is refused with an error.
        foreach (bad_ops[i]) begin
            i_dq_datapath_model.issue(bad_ops[i], 0, 0, 0,
                0, 0, i == 0, i == 1);
            chk_b("err", 1'b1, err);
            chk_l("length", 4'h0, length);
        end
        // A single element is both head and tail.
        i_dq_datapath_model.issue(OP_PUSH_BACK, 0, 20'h0_0100,
            0, 0, 0, 0, 0);
        i_dq_datapath_model.issue(OP_NONE, 0, 0, 0, 0, 0, 1, 1);
        chk_w("head", 16'h0010, head);
        chk_w("tail", 16'h0010, tail);
        chk_b("err", 1'b0, err);
        chk_l("length", 4'h1, length);
        // A second reset in mid-run restores the initial contents.
        i_dq_datapath_model.idle();
        reset_i = 1'b1;
        @(negedge clk_i);
        reset_i = 1'b0;
        chk_l("length", 4'h8, length);
        chk_w("tail", 16'h0000, tail);
        complete_run();
    end
endmodule // test_deque_state_vector

`default_nettype wire
